// file: ata_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module ata_host_model (
	// Clock
	input  wire logic              clk_sys,
	// Task file requests and answers
	output var ata_tf_pkg::tf_req_type tfReq,
	input  wire logic [15:0]       rdData,
	input  wire logic              rdValid
);
	// Bus idle at time zero
	initial begin
		tfReq = '0;
	end

	// One register write carried as one frame field update
	task automatic hostWrite(input logic [3:0] sel, input logic [15:0] data);
		logic [15:0] val;
		val = data;
		if (sel == ata_tf_pkg::SEL_UNIT) begin
			val[7:4] = {1'b1, data[6], 2'b10}; // Fixed unit bits and unit number zero
		end
		@(posedge clk_sys);
		#1;
		tfReq.sel = sel;
		tfReq.wdata = val;
		tfReq.wr = 1'b1;
		@(posedge clk_sys);
		#1;
		tfReq.wr = 1'b0;
		tfReq.wdata = ~val; // Released data shows no stale value
	endtask : hostWrite

	// One register read, answer awaited for a bounded time
	task automatic hostRead(input logic [3:0] sel, output logic [15:0] data);
		data = 'x;
		@(posedge clk_sys);
		#1;
		tfReq.sel = sel;
		tfReq.rd = 1'b1;
		@(posedge clk_sys);
		#1;
		tfReq.rd = 1'b0;
		tfReq.sel = ~sel;
		for (int i = 0; i < 4; i++) begin
			if (rdValid === 1'b1) begin
				data = rdData;
				break;
			end
			@(posedge clk_sys);
			#1;
		end
	endtask : hostRead
endmodule : ata_host_model
`default_nettype wire

// file: ata_task_file_registers.sv
// Summary of operation
// (RL1) Task file contents travel in link frames; one device per channel, no master/slave.
// (RL2) Data port is 16 bits, moving blocks between internal buffer and host.
// (RL3) Error bits: 7 bad block, 6 uncorrectable, 4 id missing, 0 general; 5,3,1 zero.
// (RL4) Error bit 2 set on not-ready or write-fault abort, or invalid command.
// (RL5) Error detail is meaningful whenever status error bit is set.
// (RL6) A zero transfer count means 256 sectors.
// (RL7) Count reads zero after success, remaining sectors after failure.
// (RL8) Block address: low, mid, high bytes then unit bits 3-0 as bits 27-24.
// (RL9) Unit bit 6 selects cylinder/head/sector (0) or block addressing (1).
// (RL10) Unit bits 3-0 are head number, or address bits 27-24 in block mode.
// (RL11) Host writes unit bits 7 and 5 as one and bit 4 as zero.
// (RL12) Primary state read clears pending interrupt; auxiliary read leaves it.
// (RL13) While busy the host is locked out and other state bits are invalid.
// (RL14) Ready is clear after power-up until a command can be accepted.
// (RL15) State bit 5 write fault, bit 4 seek complete when ready, bit 1 zero.
// (RL16) State bit 3 set while the device wants a data port transfer.
// (RL17) State bit 2 flags corrected data; it does not stop a multi-sector read.
// (RL18) State bit 0 marks the previous command ended in error.
// (RL19) Control bit 7 picks previous shadow values; any command block write clears it.
// (RL20) Control bit 2 holds the device in soft reset until written back to zero.
// (RL21) Control bit 1 disables interrupts when one; zero after power-on and reset.
// (RL22) Legacy address: bit 6 low while writing, bits 5-2 inverted head, drive selects.
// (RL23) If enabled, interrupt rises on completion or data request until state read.
`timescale 1ns/1ns
`default_nettype none
module ata_task_file_registers #(
	parameter int DATA_WIDTH = 16
) (
	// Clock and reset
	input  wire logic                       clk_sys,
	input  wire logic                       rst_b,
	// Task file access from the frame decoder
	input  wire ata_tf_pkg::tf_req_type     tfReq,
	output logic [15:0]                     rdData,
	output logic                            rdValid,
	output logic                            irqOut,
	// Command issue toward the storage core
	output logic                            cmdStart,
	output logic [7:0]                      cmdCode,
	output logic [7:0]                      featureCode,
	output logic [8:0]                      sectorTotal,
	output logic [27:0]                     blockAddress,
	output logic                            lbaMode,
	output logic                            softReset,
	// Storage core state and events
	input  wire logic                       coreReady,
	input  wire logic                       dataWanted,
	input  wire logic                       writeActive,
	input  wire logic [7:0]                 remainingCount,
	input  wire ata_tf_pkg::core_event_type coreEvent,
	// Data buffer stream
	input  wire logic [DATA_WIDTH-1:0]      bufRdData,
	output logic                            bufRdTake,
	output logic [DATA_WIDTH-1:0]           bufWrData,
	output logic                            bufWrValid
);
	initial begin
		if (DATA_WIDTH != 16)
			$error("Data port width must be 16");
	end

	ata_tf_pkg::phase_type phaseReg;
	logic [7:0]            tfCur [ata_tf_pkg::TF_SHADOWS];
	logic [7:0]            tfPrev [ata_tf_pkg::TF_SHADOWS];
	logic [7:0]            errorReg;
	logic                  errFlag;
	logic                  faultFlag;
	logic                  corrFlag;
	logic                  prevSel;
	logic                  nIenReg;
	logic                  srstReg;
	logic                  intPending;
	logic                  drqLast;
	logic                  cmdWr;
	logic                  cmdBlockWr;
	logic                  localAbort;
	logic                  accept;
	logic                  intSet;
	logic                  idle;
	logic [7:0]            stateByte;

	// Decode of host writes; command block is locked while not idle
	assign idle       = (phaseReg == ata_tf_pkg::PH_IDLE);
	assign cmdBlockWr = tfReq.wr && !tfReq.sel[3] && idle; // [RL13]
	assign cmdWr      = cmdBlockWr && (tfReq.sel == ata_tf_pkg::SEL_STATCMD);
	assign localAbort = cmdWr && (!coreReady || faultFlag); // [RL4]
	assign accept     = cmdWr && !localAbort;
	assign intSet     = !nIenReg && ((phaseReg == ata_tf_pkg::PH_BUSY && coreEvent.done)
		|| localAbort || (dataWanted && !drqLast)); // [RL23]

	// Device state byte; only busy is shown while the device owns the file
	always_comb begin
		stateByte = 8'h00;
		if (!idle) begin
			stateByte = ata_tf_pkg::BUSY_ONLY; // [RL13]
		end else begin
			stateByte[ata_tf_pkg::ST_RDY]  = coreReady; // [RL14]
			stateByte[ata_tf_pkg::ST_DWF]  = faultFlag; // [RL15]
			stateByte[ata_tf_pkg::ST_DSC]  = coreReady; // [RL15]
			stateByte[ata_tf_pkg::ST_DRQ]  = dataWanted; // [RL16]
			stateByte[ata_tf_pkg::ST_CORRECTED_DATA_FLAG] = corrFlag; // [RL17]
			stateByte[ata_tf_pkg::ST_ERR]  = errFlag; // [RL18]
		end
	end

	// Read selection of a shadowed byte honouring the previous-value flag
	function automatic logic [7:0] shadowRead(input int ix);
		shadowRead = prevSel ? tfPrev[ix] : tfCur[ix]; // [RL19]
	endfunction : shadowRead

	// Command phase: idle, busy with the core, or held in soft reset
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			phaseReg <= ata_tf_pkg::PH_IDLE;
		end else if (srstReg) begin
			phaseReg <= ata_tf_pkg::PH_RESET; // [RL20]
		end else begin
			unique case (phaseReg)
				ata_tf_pkg::PH_IDLE: begin
					if (accept)
						phaseReg <= ata_tf_pkg::PH_BUSY;
				end
				ata_tf_pkg::PH_BUSY: begin
					if (coreEvent.done)
						phaseReg <= ata_tf_pkg::PH_IDLE;
				end
				ata_tf_pkg::PH_RESET: begin
					phaseReg <= ata_tf_pkg::PH_IDLE;
				end
				default: begin
					phaseReg <= ata_tf_pkg::PH_IDLE;
				end
			endcase
		end
	end

	// Shadowed task file bytes, current and previous values
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < ata_tf_pkg::TF_SHADOWS; i++) begin
				tfCur[i]  <= ata_tf_pkg::ADDR_RESET;
				tfPrev[i] <= ata_tf_pkg::ADDR_RESET;
			end
			tfCur[ata_tf_pkg::IX_COUNT] <= ata_tf_pkg::COUNT_RESET;
			tfCur[ata_tf_pkg::IX_LOW]   <= ata_tf_pkg::LOW_RESET;
			tfCur[ata_tf_pkg::IX_UNIT]  <= ata_tf_pkg::UNIT_RESET;
		end else if (srstReg) begin
			tfCur[ata_tf_pkg::IX_COUNT] <= ata_tf_pkg::COUNT_RESET;
			tfCur[ata_tf_pkg::IX_LOW]   <= ata_tf_pkg::LOW_RESET;
			tfCur[ata_tf_pkg::IX_MID]   <= ata_tf_pkg::ADDR_RESET;
			tfCur[ata_tf_pkg::IX_HIGH]  <= ata_tf_pkg::ADDR_RESET;
			tfCur[ata_tf_pkg::IX_UNIT]  <= ata_tf_pkg::UNIT_RESET;
		end else if (phaseReg == ata_tf_pkg::PH_BUSY && coreEvent.done) begin
			// Success leaves zero, failure leaves what is still owed
			tfCur[ata_tf_pkg::IX_COUNT] <= (coreEvent.abort || coreEvent.badBlock
				|| coreEvent.uncorrectable || coreEvent.idMissing || coreEvent.general)
				? remainingCount : 8'h00; // [RL7]
		end else begin
			for (int i = 0; i < ata_tf_pkg::TF_SHADOWS; i++) begin
				if (cmdBlockWr && tfReq.sel == ata_tf_pkg::SEL_COUNT + 4'(i)) begin
					tfPrev[i] <= tfCur[i];
					tfCur[i]  <= tfReq.wdata[7:0];
				end
			end
		end
	end

	// Error detail, captured at completion and cleared at each new command
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			errorReg <= 8'h00;
			errFlag  <= 1'b0;
		end else if (srstReg || accept) begin
			errorReg <= 8'h00;
			errFlag  <= 1'b0;
		end else if (localAbort) begin
			errorReg <= 8'h00;
			errorReg[ata_tf_pkg::ERR_COMMAND_ABORTED_FLAG] <= 1'b1; // [RL4]
			errFlag  <= 1'b1;
		end else if (phaseReg == ata_tf_pkg::PH_BUSY && coreEvent.done) begin
			errorReg <= 8'h00;
			errorReg[ata_tf_pkg::ERR_BADBLK] <= coreEvent.badBlock; // [RL3]
			errorReg[ata_tf_pkg::ERR_UNC]    <= coreEvent.uncorrectable; // [RL3]
			errorReg[ata_tf_pkg::ERR_SECTOR_ID_MISSING_FLAG]   <= coreEvent.idMissing; // [RL3]
			errorReg[ata_tf_pkg::ERR_COMMAND_ABORTED_FLAG]   <= coreEvent.abort; // [RL4]
			errorReg[ata_tf_pkg::ERR_GEN]    <= coreEvent.general; // [RL3]
			errFlag  <= coreEvent.abort || coreEvent.badBlock || coreEvent.uncorrectable
				|| coreEvent.idMissing || coreEvent.general; // [RL5] [RL18]
		end
	end

	// Write fault and corrected data flags; fault survives until soft reset
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			faultFlag <= 1'b0;
			corrFlag  <= 1'b0;
		end else begin
			if (coreEvent.writeFault)
				faultFlag <= 1'b1; // [RL15]
			else if (srstReg)
				faultFlag <= 1'b0;
			if (coreEvent.corrected)
				corrFlag <= 1'b1; // [RL17]
			else if (accept || srstReg)
				corrFlag <= 1'b0;
		end
	end

	// Device control: previous-value select, soft reset hold, interrupt disable
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prevSel <= 1'b0;
			srstReg <= 1'b0;
			nIenReg <= 1'b0; // [RL21]
		end else if (tfReq.wr && tfReq.sel == ata_tf_pkg::SEL_AUXCTL) begin
			prevSel <= tfReq.wdata[ata_tf_pkg::DC_PREV];
			srstReg <= tfReq.wdata[ata_tf_pkg::DC_SRST]; // [RL20]
			nIenReg <= tfReq.wdata[ata_tf_pkg::DC_NIEN] && !tfReq.wdata[ata_tf_pkg::DC_SRST]; // [RL21]
		end else if (cmdBlockWr) begin
			prevSel <= 1'b0; // [RL19]
		end
	end

	// Interrupt pending: set wins over the clearing read of the primary state
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			intPending <= 1'b0;
			drqLast    <= 1'b0;
			irqOut     <= 1'b0;
		end else begin
			drqLast <= dataWanted;
			if (intSet)
				intPending <= 1'b1; // [RL23]
			else if (srstReg || (tfReq.rd && tfReq.sel == ata_tf_pkg::SEL_STATCMD))
				intPending <= 1'b0; // [RL12]
			irqOut <= (intPending || intSet) && !nIenReg && !srstReg; // [RL21]
		end
	end

	// Read answers, one cycle after the request
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdData  <= 16'h0000;
			rdValid <= 1'b0;
		end else begin
			rdValid <= tfReq.rd; // [RL1]
			if (tfReq.rd) begin
				unique case (tfReq.sel)
					ata_tf_pkg::SEL_DATA:    rdData <= bufRdData; // [RL2]
					ata_tf_pkg::SEL_ERRFEAT: rdData <= {8'h00, errorReg}; // [RL3]
					4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
						rdData <= {8'h00, shadowRead(int'(tfReq.sel - ata_tf_pkg::SEL_COUNT))};
					end
					ata_tf_pkg::SEL_STATCMD: rdData <= {8'h00, stateByte};
					ata_tf_pkg::SEL_AUXCTL:  rdData <= {8'h00, stateByte}; // [RL12]
					ata_tf_pkg::SEL_LEGACY: begin
						rdData <= {8'h00, 1'b0, !writeActive,
							~tfCur[ata_tf_pkg::IX_UNIT][3:0], 1'b1, 1'b0}; // [RL22]
					end
					default:                 rdData <= 16'h0000;
				endcase
			end
		end
	end

	// Data port stream to and from the internal buffer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			bufRdTake  <= 1'b0;
			bufWrValid <= 1'b0;
			bufWrData  <= '0;
		end else begin
			bufRdTake  <= tfReq.rd && tfReq.sel == ata_tf_pkg::SEL_DATA && dataWanted; // [RL2]
			bufWrValid <= tfReq.wr && tfReq.sel == ata_tf_pkg::SEL_DATA && dataWanted; // [RL2]
			if (tfReq.wr && tfReq.sel == ata_tf_pkg::SEL_DATA)
				bufWrData <= tfReq.wdata;
		end
	end

	// Command issue; parameters frozen at acceptance, feature code taken at each idle feature write
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmdStart     <= 1'b0;
			cmdCode      <= 8'h00;
			featureCode  <= 8'h00;
			sectorTotal  <= 9'h000;
			blockAddress <= 28'h0000000;
			lbaMode      <= 1'b0;
			softReset    <= 1'b0;
		end else begin
			cmdStart  <= accept;
			softReset <= srstReg; // [RL20]
			if (tfReq.wr && tfReq.sel == ata_tf_pkg::SEL_ERRFEAT && idle)
				featureCode <= tfReq.wdata[7:0];
			if (accept) begin
				cmdCode     <= tfReq.wdata[7:0];
				sectorTotal <= (tfCur[ata_tf_pkg::IX_COUNT] == 8'h00) ? ata_tf_pkg::FULL_COUNT
					: {1'b0, tfCur[ata_tf_pkg::IX_COUNT]}; // [RL6]
				lbaMode     <= tfCur[ata_tf_pkg::IX_UNIT][ata_tf_pkg::DH_LBA]; // [RL9]
				// Unit low nibble is head number or top address bits [RL10]
				blockAddress <= {tfCur[ata_tf_pkg::IX_UNIT][3:0], tfCur[ata_tf_pkg::IX_HIGH],
					tfCur[ata_tf_pkg::IX_MID], tfCur[ata_tf_pkg::IX_LOW]}; // [RL8]
			end
		end
	end

	AST_ABORT_NOT_READY: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL4]
		(cmdWr && !coreReady && !srstReg) |=> (errorReg[ata_tf_pkg::ERR_COMMAND_ABORTED_FLAG] && errFlag && !cmdStart))
		else $error("Command while not ready was not aborted");
	AST_COUNT_ZERO_OK: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL7]
		(phaseReg == ata_tf_pkg::PH_BUSY && coreEvent.done && !srstReg && !coreEvent.abort
		&& !coreEvent.badBlock && !coreEvent.uncorrectable && !coreEvent.idMissing
		&& !coreEvent.general) |=> (tfCur[ata_tf_pkg::IX_COUNT] == 8'h00 && !errFlag))
		else $error("Count not zero after success");
	AST_ZERO_IS_256: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL6]
		(accept && !srstReg && tfCur[ata_tf_pkg::IX_COUNT] == 8'h00) |=> (sectorTotal == 9'h100))
		else $error("Zero count not taken as 256");
	AST_LBA_LAYOUT: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL8]
		cmdStart |-> (blockAddress[27:24] == $past(tfCur[ata_tf_pkg::IX_UNIT][3:0])
		&& blockAddress[7:0] == $past(tfCur[ata_tf_pkg::IX_LOW])))
		else $error("Block address assembled wrongly");
	AST_STATE_READ_CLEARS: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL12]
		(tfReq.rd && tfReq.sel == ata_tf_pkg::SEL_STATCMD && !intSet) |=> !intPending)
		else $error("Primary state read left interrupt pending");
	AST_AUX_KEEPS: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL12]
		(tfReq.rd && tfReq.sel == ata_tf_pkg::SEL_AUXCTL && intPending && !srstReg) |=> intPending)
		else $error("Auxiliary read cleared interrupt");
	AST_BUSY_MASKS: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL13]
		(!idle && tfReq.rd && tfReq.sel == ata_tf_pkg::SEL_STATCMD) |=> (rdData == 16'h0080 && rdValid))
		else $error("State bits shown while busy");
	AST_SRST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL20]
		srstReg [*2] |-> (phaseReg == ata_tf_pkg::PH_RESET && softReset))
		else $error("Soft reset not held");
	AST_NIEN_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL21]
		$past(nIenReg) && nIenReg |-> !irqOut)
		else $error("Interrupt raised while disabled");
	AST_PREV_CLEARED: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL19]
		(cmdBlockWr && !srstReg) |=> !prevSel)
		else $error("Command block write left previous select");
	AST_ERR_ZERO_BITS: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL3]
		(tfReq.rd && tfReq.sel == ata_tf_pkg::SEL_ERRFEAT) |=> (rdData[7:0] & 8'h2A) == 8'h00)
		else $error("Reserved error bits set");
	AST_ERR_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL3]
		(phaseReg == ata_tf_pkg::PH_BUSY && coreEvent.done && !srstReg)
		|=> (errorReg[ata_tf_pkg::ERR_UNC] == $past(coreEvent.uncorrectable)))
		else $error("Uncorrectable bit not captured");
	AST_ERR_FLAG_DETAIL: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL5] [RL18]
		(phaseReg == ata_tf_pkg::PH_BUSY && coreEvent.done && coreEvent.general && !srstReg)
		|=> (errFlag && errorReg[ata_tf_pkg::ERR_GEN]))
		else $error("Failed command left no error flag");
	AST_FAULT_ABORT: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL4]
		(cmdWr && faultFlag && !srstReg) |=> (errorReg[ata_tf_pkg::ERR_COMMAND_ABORTED_FLAG] && !cmdStart))
		else $error("Command under write fault was not aborted");
	AST_STATE_FIELDS: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL14] [RL15] [RL16]
		(tfReq.rd && tfReq.sel == ata_tf_pkg::SEL_STATCMD && idle) |=> (rdData[ata_tf_pkg::ST_RDY]
		== $past(coreReady) && rdData[ata_tf_pkg::ST_DRQ] == $past(dataWanted)
		&& rdData[ata_tf_pkg::ST_DWF] == $past(faultFlag)))
		else $error("State fields do not follow the device");
	AST_SRST_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL21]
		($past(srstReg) && srstReg) |-> (!nIenReg && !irqOut))
		else $error("Interrupt active during soft reset");
	AST_LEGACY_BITS: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL22]
		(tfReq.rd && tfReq.sel == ata_tf_pkg::SEL_LEGACY) |=> (rdData[6] == !$past(writeActive)
		&& rdData[5:2] == ~$past(tfCur[ata_tf_pkg::IX_UNIT][3:0])))
		else $error("Legacy address bits wrong");
	AST_DATA_WORD: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL2]
		(tfReq.wr && tfReq.sel == ata_tf_pkg::SEL_DATA && dataWanted)
		|=> (bufWrValid && bufWrData == $past(tfReq.wdata)))
		else $error("Data word not passed to buffer");
endmodule : ata_task_file_registers
`default_nettype wire

// file: ata_task_file_registers_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ata_task_file_registers_bench;
	logic                       clk_sys = 1'b0;
	logic                       rst_b = 1'b0;
	ata_tf_pkg::tf_req_type     tfReq;
	logic [15:0]                rdData;
	logic                       rdValid, irqOut, cmdStart, lbaMode, softReset;
	logic [7:0]                 cmdCode, featureCode;
	logic [8:0]                 sectorTotal;
	logic [27:0]                blockAddress;
	logic                       coreReady = 1'b1;
	logic                       dataWanted = 1'b0;
	logic                       writeActive = 1'b0;
	logic [7:0]                 remainingCount = 8'h00;
	ata_tf_pkg::core_event_type coreEvent = '0;
	logic [15:0]                bufRdData = 16'h1234;
	logic                       bufRdTake, bufWrValid;
	logic [15:0]                bufWrData;
	int                         nFail = 0;
	int                         nCompared = 0;
	int                         nTake = 0;

	// Clock at 100 MHz
	always #5 clk_sys = ~clk_sys;

	ata_task_file_registers u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .tfReq(tfReq),
		.rdData(rdData), .rdValid(rdValid), .irqOut(irqOut), .cmdStart(cmdStart),
		.cmdCode(cmdCode), .featureCode(featureCode), .sectorTotal(sectorTotal),
		.blockAddress(blockAddress), .lbaMode(lbaMode), .softReset(softReset),
		.coreReady(coreReady), .dataWanted(dataWanted), .writeActive(writeActive),
		.remainingCount(remainingCount), .coreEvent(coreEvent), .bufRdData(bufRdData),
		.bufRdTake(bufRdTake), .bufWrData(bufWrData), .bufWrValid(bufWrValid));

	ata_host_model u_host (.clk_sys(clk_sys), .tfReq(tfReq), .rdData(rdData),
		.rdValid(rdValid));

	// Count buffer words consumed by host reads
	always @(posedge clk_sys) begin
		if (bufRdTake === 1'b1) begin
			nTake++;
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp) begin
			nFail++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic readCheck(input string what, input logic [3:0] sel, input logic [7:0] exp);
		logic [15:0] v;
		u_host.hostRead(sel, v);
		check(what, {8'h00, v[7:0]}, {8'h00, exp});
	endtask : readCheck

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	// Core reports the end of a command
	task automatic endCommand(input logic [7:0] ev, input logic [7:0] rem);
		remainingCount = rem;
		tick(1);
		coreEvent = ev;
		tick(1);
		coreEvent = '0;
		tick(2);
	endtask : endCommand

	task automatic testReset;
		readCheck("count", ata_tf_pkg::SEL_COUNT, 8'h01);
		readCheck("low", 4'h3, 8'h01);
		readCheck("mid", 4'h4, 8'h00);
		readCheck("unit", ata_tf_pkg::SEL_UNIT, 8'hA0);
		readCheck("state", ata_tf_pkg::SEL_STATCMD, 8'h50);
		$display("reset values done");
	endtask : testReset

	task automatic testCommand;
		u_host.hostWrite(ata_tf_pkg::SEL_COUNT, 16'h0000);
		u_host.hostWrite(ata_tf_pkg::SEL_ERRFEAT, 16'h000F);
		u_host.hostWrite(4'h3, 16'h0011);
		u_host.hostWrite(4'h4, 16'h0022);
		u_host.hostWrite(4'h5, 16'h0033);
		u_host.hostWrite(ata_tf_pkg::SEL_UNIT, 16'h00E5);
		u_host.hostWrite(ata_tf_pkg::SEL_STATCMD, 16'h0020);
		check("cmdStart", {15'h0000, cmdStart}, 16'h0001);
		check("total", {7'h00, sectorTotal}, 16'h0100);
		check("addr", blockAddress[15:0], 16'h2211);
		check("addrHi", {4'h0, blockAddress[27:16]}, 16'h0533);
		check("mode", {15'h0000, lbaMode}, 16'h0001);
		check("code", {cmdCode, featureCode}, 16'h200F);
		readCheck("busy", ata_tf_pkg::SEL_STATCMD, 8'h80);
		u_host.hostWrite(4'h3, 16'h0099);
		endCommand(8'h80, 8'h00);
		readCheck("lowKept", 4'h3, 8'h11);
		readCheck("count", ata_tf_pkg::SEL_COUNT, 8'h00);
		check("irq", {15'h0000, irqOut}, 16'h0001);
		readCheck("aux", ata_tf_pkg::SEL_AUXCTL, 8'h50);
		tick(2);
		check("irqAux", {15'h0000, irqOut}, 16'h0001);
		readCheck("state", ata_tf_pkg::SEL_STATCMD, 8'h50);
		tick(2);
		check("irqClr", {15'h0000, irqOut}, 16'h0000);
		$display("command done");
	endtask : testCommand

	task automatic testFailure;
		u_host.hostWrite(ata_tf_pkg::SEL_COUNT, 16'h0008);
		u_host.hostWrite(ata_tf_pkg::SEL_STATCMD, 16'h0030);
		endCommand(8'hFC, 8'h05);
		readCheck("state", ata_tf_pkg::SEL_STATCMD, 8'h51);
		readCheck("error", ata_tf_pkg::SEL_ERRFEAT, 8'hD5);
		readCheck("count", ata_tf_pkg::SEL_COUNT, 8'h05);
		coreReady = 1'b0;
		u_host.hostWrite(ata_tf_pkg::SEL_STATCMD, 16'h0020);
		check("refused", {15'h0000, cmdStart}, 16'h0000);
		tick(2);
		readCheck("notReady", ata_tf_pkg::SEL_STATCMD, 8'h01);
		readCheck("abort", ata_tf_pkg::SEL_ERRFEAT, 8'h04);
		coreReady = 1'b1;
		$display("failure done");
	endtask : testFailure

	task automatic testPrevious;
		u_host.hostWrite(ata_tf_pkg::SEL_COUNT, 16'h0012);
		u_host.hostWrite(ata_tf_pkg::SEL_COUNT, 16'h0034);
		u_host.hostWrite(ata_tf_pkg::SEL_AUXCTL, 16'h0080);
		readCheck("prev", ata_tf_pkg::SEL_COUNT, 8'h12);
		u_host.hostWrite(4'h4, 16'h0055);
		readCheck("recent", ata_tf_pkg::SEL_COUNT, 8'h34);
		$display("readback done");
	endtask : testPrevious

	task automatic testMaskAndLegacy;
		u_host.hostWrite(ata_tf_pkg::SEL_AUXCTL, 16'h0002);
		u_host.hostWrite(ata_tf_pkg::SEL_UNIT, 16'h00A5);
		u_host.hostWrite(ata_tf_pkg::SEL_STATCMD, 16'h0020);
		check("chs", {15'h0000, lbaMode}, 16'h0000);
		check("head", {12'h000, blockAddress[27:24]}, 16'h0005);
		endCommand(8'h80, 8'h00);
		check("masked", {15'h0000, irqOut}, 16'h0000);
		readCheck("legacy", ata_tf_pkg::SEL_LEGACY, 8'h6A);
		writeActive = 1'b1;
		readCheck("writing", ata_tf_pkg::SEL_LEGACY, 8'h2A);
		writeActive = 1'b0;
		$display("mask and legacy done");
	endtask : testMaskAndLegacy

	task automatic testData;
		logic [15:0] v;
		u_host.hostWrite(ata_tf_pkg::SEL_AUXCTL, 16'h0000);
		dataWanted = 1'b1;
		tick(2);
		check("drqIrq", {15'h0000, irqOut}, 16'h0001);
		readCheck("drq", ata_tf_pkg::SEL_STATCMD, 8'h58);
		u_host.hostWrite(ata_tf_pkg::SEL_DATA, 16'hABCD);
		check("wrValid", {15'h0000, bufWrValid}, 16'h0001);
		check("wrData", bufWrData, 16'hABCD);
		u_host.hostRead(ata_tf_pkg::SEL_DATA, v);
		check("rdWord", v, 16'h1234);
		tick(1);
		check("takes", nTake[15:0], 16'h0001);
		dataWanted = 1'b0;
		u_host.hostWrite(ata_tf_pkg::SEL_DATA, 16'h5A5A);
		check("noWrite", {15'h0000, bufWrValid}, 16'h0000);
		$display("data port done");
	endtask : testData

	task automatic testFault;
		coreEvent = 8'h03;
		tick(1);
		coreEvent = '0;
		readCheck("fault", ata_tf_pkg::SEL_STATCMD, 8'h74);
		u_host.hostWrite(ata_tf_pkg::SEL_STATCMD, 16'h0020);
		check("faultCmd", {15'h0000, cmdStart}, 16'h0000);
		readCheck("faultErr", ata_tf_pkg::SEL_ERRFEAT, 8'h04);
		$display("fault done");
	endtask : testFault

	task automatic testSoftReset;
		u_host.hostWrite(4'h3, 16'h0099);
		u_host.hostWrite(ata_tf_pkg::SEL_AUXCTL, 16'h0006);
		tick(1);
		check("soft", {15'h0000, softReset}, 16'h0001);
		readCheck("held", ata_tf_pkg::SEL_STATCMD, 8'h80);
		u_host.hostWrite(ata_tf_pkg::SEL_AUXCTL, 16'h0000);
		tick(2);
		check("released", {15'h0000, softReset}, 16'h0000);
		readCheck("low", 4'h3, 8'h01);
		readCheck("state", ata_tf_pkg::SEL_STATCMD, 8'h50);
		$display("soft reset done");
	endtask : testSoftReset

	task automatic conclude;
		$display("compared %0d mismatches %0d", nCompared, nFail);
		if (nFail == 0 && nCompared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	// Watchdog against a hang
	initial begin
		#100000;
		nFail++;
		conclude();
	end

	// Main sequence
	initial begin
		tick(12);
		rst_b = 1'b1;
		testReset();
		testCommand();
		testFailure();
		testPrevious();
		testMaskAndLegacy();
		testData();
		testFault();
		testSoftReset();
		conclude();
	end
endmodule : ata_task_file_registers_bench
`default_nettype wire

// file: ata_tf_pkg.sv
package ata_tf_pkg;
	// Task file register selects, command block then control block
	localparam logic [3:0] SEL_DATA    = 4'h0;
	localparam logic [3:0] SEL_ERRFEAT = 4'h1;
	localparam logic [3:0] SEL_COUNT   = 4'h2;
	localparam logic [3:0] SEL_UNIT    = 4'h6;
	localparam logic [3:0] SEL_STATCMD = 4'h7;
	localparam logic [3:0] SEL_AUXCTL  = 4'hE;
	localparam logic [3:0] SEL_LEGACY  = 4'hF;
	// Shadowed byte registers: count, low, mid, high, unit
	localparam int         TF_SHADOWS  = 5;
	localparam int         IX_COUNT    = 0;
	localparam int         IX_LOW      = 1;
	localparam int         IX_MID      = 2;
	localparam int         IX_HIGH     = 3;
	localparam int         IX_UNIT     = 4;
	// Error detail fields
	localparam int ERR_BADBLK = 7;
	localparam int ERR_UNC    = 6;
	localparam int ERR_SECTOR_ID_MISSING_FLAG   = 4;
	localparam int ERR_COMMAND_ABORTED_FLAG   = 2;
	localparam int ERR_GEN    = 0;
	// Device state fields
	localparam int ST_BUSY = 7;
	localparam int ST_RDY  = 6;
	localparam int ST_DWF  = 5;
	localparam int ST_DSC  = 4;
	localparam int ST_DRQ  = 3;
	localparam int ST_CORRECTED_DATA_FLAG = 2;
	localparam int ST_ERR  = 0;
	// Device control and unit fields
	localparam int DC_PREV = 7;
	localparam int DC_SRST = 2;
	localparam int DC_NIEN = 1;
	localparam int DH_LBA  = 6;
	// Reset values and the full transfer of a zero count
	localparam logic [7:0] UNIT_RESET  = 8'hA0;
	localparam logic [7:0] COUNT_RESET = 8'h01;
	localparam logic [7:0] ADDR_RESET  = 8'h00;
	localparam logic [7:0] LOW_RESET   = 8'h01;
	localparam logic [8:0] FULL_COUNT  = 9'h100;
	localparam logic [7:0] BUSY_ONLY   = 8'h80;

	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_BUSY  = 2'b01,
		PH_RESET = 2'b10
	} phase_type;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  sel;
		logic [15:0] wdata;
	} tf_req_type;

	typedef struct packed {
		logic done;
		logic abort;
		logic badBlock;
		logic uncorrectable;
		logic idMissing;
		logic general;
		logic writeFault;
		logic corrected;
	} core_event_type;
endpackage : ata_tf_pkg
